//--- csps_ctrl.sv
`timescale 1ns/1ps
`include "csps_defines.svh"

module csps_ctrl
  import csps_pkg::*;
#(
  parameter int MON_DELAY_CYC = `CSPS_MON_DELAY_CYC,
  parameter int PLL_LOCK_CYC  = `CSPS_PLL_LOCK_CYC
) (
  input  wire logic       ref_clk,
  input  wire logic       arst_n,
  input  wire logic [2:0] initial_osc_sel,
  input  wire logic       monitor_enable,
  input  wire logic       clock_cfg_locked,
  input  wire logic       osc_ctrl_wr,
  input  wire logic [15:0] osc_ctrl_wdata,
  input  wire logic       osc_clk_tick,
  input  wire logic       osc_clk_ok,
  input  wire logic       pll_locked,
  input  wire logic       psave_req,
  input  wire logic       psave_idle,
  input  wire logic       irq_enabled_pending,
  input  wire logic       wdt_enable,
  input  wire logic       wdt_timeout,
  output logic            cpu_run,
  output logic            cpu_clk_en,
  output logic            periph_clk_en,
  output logic            sysclk_osc_en,
  output logic            low_power_rc_en,
  output logic            wdt_clear,
  output logic            monitor_active,
  output logic            clock_fail_trap,
  output logic [2:0]      cur_osc_sel,
  output logic            in_sleep,
  output logic            in_idle,
  output logic            wake_pulse
);

  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  csps_state_e state_r;
  logic [`CSPS_OST_W-1:0] ost_cnt_r;
  logic                   ost_done_r;
  logic [31:0]            lock_cnt_r;
  logic                   clk_valid_r;
  logic [31:0]            mon_cnt_r;
  logic                   mon_armed_r;
  logic                   wake_hold_r;
  logic                   entry_idle_r;
  logic                   started_r;
  csps_osc_t              osc_r;

  logic is_xtal;
  logic is_pll;
  logic wake_evt;
  logic clk_fail;
  logic osc_wr_ok;

  // --------------------------------------------------------------------
  // Decode
  // --------------------------------------------------------------------
  always_comb begin
    is_xtal  = (osc_r == `CSPS_SEL_XTAL) || (osc_r == `CSPS_SEL_XTAL_PLL);
    is_pll   = (osc_r == `CSPS_SEL_FAST_RC_PLL) || (osc_r == `CSPS_SEL_XTAL_PLL)
               || (osc_r == `CSPS_SEL_EXT_PLL);
    wake_evt = irq_enabled_pending || wdt_timeout;
    // Sleep stops the source, so a missing clock there is no failure
    clk_fail  = mon_armed_r && !osc_clk_ok && (state_r != CSPS_ST_SLEEP);
    // Run-time switch only while unlocked and executing
    osc_wr_ok = osc_ctrl_wr && !clock_cfg_locked && (state_r == CSPS_ST_RUN);
  end

  // --------------------------------------------------------------------
  // Oscillator selection
  // --------------------------------------------------------------------
  // Strap is taken on the first clock after reset release, never in reset
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      started_r <= 1'b0;
    end else begin
      started_r <= 1'b1;
    end
  end

  // Fallback outranks a write landing in the same cycle
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      osc_r <= `CSPS_SEL_RST;
    end else if (!started_r) begin
      osc_r <= initial_osc_sel;
    end else if (clk_fail && osc_r != `CSPS_SEL_FAST_RC) begin
      osc_r <= `CSPS_SEL_FAST_RC;
    end else if (osc_wr_ok) begin
      osc_r <= osc_ctrl_wdata[`CSPS_NEXT_OSC_MSB:`CSPS_NEXT_OSC_LSB];
    end
  end
  // Sleep never touches osc_r, so wake resumes on it

  // --------------------------------------------------------------------
  // Clock release: start-up timer and PLL lock
  // --------------------------------------------------------------------
  logic sel_change;
  assign sel_change = !started_r || osc_wr_ok;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ost_cnt_r  <= '0;
      ost_done_r <= 1'b0;
    end else if (sel_change || state_r == CSPS_ST_SLEEP) begin
      ost_cnt_r  <= '0;
      ost_done_r <= 1'b0;
    end else if (!is_xtal) begin
      ost_done_r <= 1'b1;
    end else if (!ost_done_r && osc_clk_tick) begin
      ost_cnt_r <= ost_cnt_r + 1'b1;
      if (ost_cnt_r == `CSPS_OST_W'(`CSPS_OST_PERIODS - 1)) begin
        ost_done_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      lock_cnt_r  <= '0;
      clk_valid_r <= 1'b0;
    end else if (sel_change || state_r == CSPS_ST_SLEEP) begin
      lock_cnt_r  <= '0;
      clk_valid_r <= 1'b0;
    end else if (ost_done_r && !clk_valid_r) begin
      if (!is_pll) begin
        clk_valid_r <= 1'b1;
      end else if (pll_locked) begin
        lock_cnt_r <= lock_cnt_r + 32'h1;
        if (lock_cnt_r >= 32'(PLL_LOCK_CYC - 1)) begin
          clk_valid_r <= 1'b1;
        end
      end
    end
  end

  // --------------------------------------------------------------------
  // Clock fail monitor
  // --------------------------------------------------------------------
  // Delay applies only to crystal/PLL sources; others arm at release
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      mon_cnt_r   <= '0;
      mon_armed_r <= 1'b0;
    end else if (!monitor_enable || !started_r || state_r == CSPS_ST_SLEEP) begin
      mon_cnt_r   <= '0;
      mon_armed_r <= 1'b0;
    end else if (!mon_armed_r) begin
      if (!(is_xtal || is_pll)) begin
        mon_armed_r <= 1'b1;
      end else begin
        mon_cnt_r <= mon_cnt_r + 32'h1;
        if (mon_cnt_r >= 32'(MON_DELAY_CYC - 1)) begin
          mon_armed_r <= 1'b1;
        end
      end
    end
  end

  // Sticky until reset; cleared only by a full device reset
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      clock_fail_trap <= 1'b0;
    end else if (clk_fail) begin
      clock_fail_trap <= 1'b1;
    end
  end

  // --------------------------------------------------------------------
  // Power-save request capture
  // --------------------------------------------------------------------
  // Operand only counts when the request is taken in RUN
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      entry_idle_r <= 1'b0;
    end else if (state_r == CSPS_ST_RUN && psave_req) begin
      entry_idle_r <= psave_idle;
    end
  end

  // A wake meeting the request would else be gone by ENTER
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      wake_hold_r <= 1'b0;
    end else begin
      wake_hold_r <= (state_r == CSPS_ST_RUN) && psave_req && wake_evt;
    end
  end

  // --------------------------------------------------------------------
  // Power-save sequencing
  // --------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= CSPS_ST_WAIT_CLK;
    end else begin
      unique case (state_r)
        CSPS_ST_WAIT_CLK: begin
          if (clk_valid_r && started_r) begin
            state_r <= CSPS_ST_RUN;
          end
        end
        CSPS_ST_RUN: begin
          if (psave_req) begin
            state_r <= CSPS_ST_ENTER;
          end
        end
        CSPS_ST_ENTER: begin
          // Wake seen during the request cycle is held, not dropped
          if (wake_evt || wake_hold_r) begin
            state_r <= CSPS_ST_RUN;
          end else if (entry_idle_r) begin
            state_r <= CSPS_ST_IDLE;
          end else begin
            state_r <= CSPS_ST_SLEEP;
          end
        end
        CSPS_ST_IDLE: begin
          if (wake_evt) begin
            state_r <= CSPS_ST_RUN;
          end
        end
        CSPS_ST_SLEEP: begin
          // Source restarts, so clock release is re-qualified
          if (wake_evt) begin
            state_r <= CSPS_ST_WAIT_CLK;
          end
        end
        default: state_r <= CSPS_ST_WAIT_CLK;
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------
  // Clear stands in ENTER, one cycle ahead of the Sleep state
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      wdt_clear <= 1'b0;
    end else begin
      wdt_clear <= (state_r == CSPS_ST_RUN) && psave_req && !psave_idle
                   && wdt_enable;
    end
  end

  // A wake held over from the request cycle reports as well
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      wake_pulse <= 1'b0;
    end else begin
      wake_pulse <= (wake_evt && (state_r == CSPS_ST_ENTER ||
                    state_r == CSPS_ST_IDLE || state_r == CSPS_ST_SLEEP))
                    || (state_r == CSPS_ST_ENTER && wake_hold_r);
    end
  end

  always_comb begin
    cpu_run         = (state_r == CSPS_ST_RUN);
    cpu_clk_en      = (state_r == CSPS_ST_RUN) || (state_r == CSPS_ST_ENTER);
    periph_clk_en   = (state_r != CSPS_ST_SLEEP) && (state_r != CSPS_ST_WAIT_CLK);
    sysclk_osc_en   = (state_r != CSPS_ST_SLEEP);
    low_power_rc_en = (state_r != CSPS_ST_SLEEP) || wdt_enable;
    // Armed flag lags Sleep entry by one edge, so gate it here
    monitor_active  = mon_armed_r && (state_r != CSPS_ST_SLEEP);
  end

  // --------------------------------------------------------------------
  // Status flags
  // --------------------------------------------------------------------
  always_comb begin
    cur_osc_sel = osc_r;
    in_sleep    = (state_r == CSPS_ST_SLEEP);
    in_idle     = (state_r == CSPS_ST_IDLE);
  end

endmodule // csps_ctrl

//--- csps_defines.svh
`ifndef CSPS_DEFINES_SVH
`define CSPS_DEFINES_SVH

// ----------------------------------------------------------------------
// Timing constants
// ----------------------------------------------------------------------
`define CSPS_CLK_MHZ          250
`define CSPS_MON_DELAY_US     500
`define CSPS_MON_DELAY_CYC    (`CSPS_MON_DELAY_US * `CSPS_CLK_MHZ)
`define CSPS_PLL_LOCK_US      20
`define CSPS_PLL_LOCK_CYC     (`CSPS_PLL_LOCK_US * `CSPS_CLK_MHZ)
`define CSPS_OST_PERIODS      1024
`define CSPS_OST_W            10

// ----------------------------------------------------------------------
// Oscillator select codes and field layout
// ----------------------------------------------------------------------
`define CSPS_NEXT_OSC_MSB     10
`define CSPS_NEXT_OSC_LSB     8
`define CSPS_SEL_FAST_RC      3'h0
`define CSPS_SEL_FAST_RC_PLL  3'h1
`define CSPS_SEL_XTAL         3'h2
`define CSPS_SEL_XTAL_PLL     3'h3
`define CSPS_SEL_EXT          3'h4
`define CSPS_SEL_EXT_PLL      3'h5
`define CSPS_SEL_LOW_POWER_RC 3'h6
`define CSPS_SEL_RST          3'h0

`endif

//--- csps_pkg.sv
package csps_pkg;
  typedef enum logic [2:0] {
    CSPS_ST_WAIT_CLK,
    CSPS_ST_RUN,
    CSPS_ST_ENTER,
    CSPS_ST_SLEEP,
    CSPS_ST_IDLE
  } csps_state_e;

  typedef logic [2:0] csps_osc_t;
endpackage

//--- csps_chk.sv
`timescale 1ns/1ps
module csps_chk (
  input wire logic        ref_clk,
  input wire logic        arst_n,
  input wire logic        osc_ctrl_wr,
  input wire logic        clock_cfg_locked,
  input wire logic        osc_clk_ok,
  input wire logic        psave_req,
  input wire logic        psave_idle,
  input wire logic        irq_enabled_pending,
  input wire logic        wdt_enable,
  input wire logic        wdt_timeout,
  input wire logic [15:0] osc_ctrl_wdata,
  input wire logic        cpu_run,
  input wire logic        cpu_clk_en,
  input wire logic        periph_clk_en,
  input wire logic        sysclk_osc_en,
  input wire logic        low_power_rc_en,
  input wire logic        wdt_clear,
  input wire logic        monitor_active,
  input wire logic        clock_fail_trap,
  input wire logic        in_sleep,
  input wire logic        in_idle,
  input wire logic        wake_pulse,
  input wire logic [2:0]  cur_osc_sel
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  wire logic wk = irq_enabled_pending || wdt_timeout;

  AST_SLP_GATE: assert property (in_sleep |-> !cpu_run && !cpu_clk_en && !periph_clk_en && !sysclk_osc_en)
    else $error("sleep gating wrong");
  AST_IDL_GATE: assert property (in_idle |-> !cpu_run && !cpu_clk_en && periph_clk_en)
    else $error("idle gating wrong");
  AST_SLP_RC: assert property (in_sleep ##1 in_sleep && wdt_enable |-> low_power_rc_en && !monitor_active)
    else $error("sleep rc or monitor wrong");
  AST_WDT_CLR: assert property (psave_req && cpu_run && !psave_idle && wdt_enable |=> wdt_clear)
    else $error("watchdog not cleared");
  AST_ENTRY: assert property (psave_req && cpu_run && !wk ##1 !wk |=>
    in_sleep == !$past(psave_idle, 2) && in_idle == $past(psave_idle, 2))
    else $error("power save entry wrong");
  AST_WAKE: assert property ((in_sleep || in_idle) && wk |=> wake_pulse && !in_sleep && !in_idle)
    else $error("no wake");
  AST_OSC_KEEP: assert property (in_sleep |=> $stable(cur_osc_sel))
    else $error("source changed in sleep");
  AST_TRAP: assert property (monitor_active && !osc_clk_ok |=> clock_fail_trap && cur_osc_sel == 3'h0)
    else $error("no fallback on fail");
  AST_LOCK: assert property (osc_ctrl_wr && clock_cfg_locked && osc_clk_ok |=> $stable(cur_osc_sel))
    else $error("locked write took");

  cover property (in_sleep ##1 wake_pulse);
  cover property (in_idle ##1 wake_pulse);
  cover property ($rose(clock_fail_trap));
endmodule // csps_chk

//--- csps_core_model.sv
`timescale 1ns/1ps
module csps_core_model (
  input  wire logic ref_clk,
  input  wire logic arst_n,
  input  wire logic cpu_run,
  input  wire logic go,
  input  wire logic op_idle,
  output logic      psave_req,
  output logic      psave_idle
);
  // Core issues no request while halted
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      psave_req  <= 1'h0;
      psave_idle <= 1'h0;
    end else begin
      psave_req  <= go && cpu_run;
      psave_idle <= op_idle;
    end
  end
endmodule // csps_core_model

//--- csps_ctrl_test.sv
`timescale 1ns/1ps
module csps_ctrl_test;
  import csps_pkg::*;
  logic ref_clk, arst_n, monitor_enable, clock_cfg_locked, osc_ctrl_wr, osc_clk_tick;
  logic osc_clk_ok, pll_locked, irq_enabled_pending, wdt_enable, wdt_timeout, go, op_idle, lk;
  logic [2:0] initial_osc_sel, code, sel_m;
  logic [15:0] osc_ctrl_wdata;
  logic psave_req, psave_idle, cpu_run, cpu_clk_en, periph_clk_en, sysclk_osc_en, low_power_rc_en;
  logic wdt_clear, monitor_active, clock_fail_trap, in_sleep, in_idle, wake_pulse;
  logic [2:0] cur_osc_sel;
  integer n_mismatch = 0, checked = 0, seed = 81300;

  csps_ctrl #(.MON_DELAY_CYC(20), .PLL_LOCK_CYC(8)) csps_ctrl_i (.*);
  csps_core_model csps_core_model_i (.ref_clk, .arst_n, .cpu_run, .go, .op_idle, .psave_req,
    .psave_idle);

  initial begin
    ref_clk = 1'h0;
    forever #2 ref_clk = ~ref_clk;
  end

  task automatic end_sim;
    $display("mismatch %0d checked %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic cmp(logic [2:0] got, logic [2:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function automatic logic [2:0] exp_sel(logic [2:0] old, logic [2:0] c, logic l);
    return l ? old : c;
  endfunction

  task automatic tk(int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic wait_run;
    for (int i = 0; i < 3000; i++) begin
      if (cpu_run === 1'h1) return;
      tk(1);
    end
    n_mismatch++;
    end_sim;
  endtask

  task automatic rst(logic [2:0] s);
    arst_n <= 1'h0;
    initial_osc_sel <= s;
    tk(2);
    cmp(cpu_run, 3'h0);
    arst_n <= 1'h1;
  endtask

  task automatic psave(logic idle);
    go <= 1'h1;
    op_idle <= idle;
    tk(1);
    go <= 1'h0;
    tk(1);
  endtask

  initial begin
    {arst_n, clock_cfg_locked, osc_ctrl_wr, irq_enabled_pending, wdt_timeout, go, op_idle} = '0;
    {monitor_enable, osc_clk_tick, osc_clk_ok, wdt_enable} = 4'hF;
    osc_ctrl_wdata = 16'h0000;
    initial_osc_sel = 3'h0;
    pll_locked = 1'h0;
    // Crystal with PLL: lock withheld past the start-up count
    rst(3'h3);
    tk(10);
    cmp(monitor_active, 3'h0);
    tk(990);
    cmp(cpu_run, 3'h0);
    tk(200);
    cmp(cpu_run, 3'h0);
    pll_locked <= 1'h1;
    wait_run;
    rst(3'h0);
    wait_run;
    cmp(monitor_active, 3'h1);
    sel_m = 3'h0;
    for (int i = 0; i < 12; i++) begin
      code = 3'($unsigned($random(seed)) % 7);
      lk = 1'($random(seed));
      sel_m = exp_sel(sel_m, code, lk);
      clock_cfg_locked <= lk;
      osc_ctrl_wr <= 1'h1;
      osc_ctrl_wdata <= {5'h00, code, 8'h00};
      tk(1);
      osc_ctrl_wr <= 1'h0;
      tk(1);
      cmp(cur_osc_sel, sel_m);
    end
    psave(1'h0);
    cmp(wdt_clear, 3'h1);
    tk(1);
    cmp(in_sleep, 3'h1);
    cmp(sysclk_osc_en, 3'h0);
    cmp(periph_clk_en, 3'h0);
    tk(1);
    cmp(low_power_rc_en, 3'h1);
    cmp(monitor_active, 3'h0);
    irq_enabled_pending <= 1'h1;
    tk(1);
    cmp(wake_pulse, 3'h1);
    cmp(cur_osc_sel, sel_m);
    irq_enabled_pending <= 1'h0;
    wait_run;
    psave(1'h1);
    tk(1);
    cmp(in_idle, 3'h1);
    cmp(periph_clk_en, 3'h1);
    wdt_timeout <= 1'h1;
    tk(1);
    cmp(wake_pulse, 3'h1);
    wdt_timeout <= 1'h0;
    wait_run;
    psave(1'h0);
    irq_enabled_pending <= 1'h1;
    tk(1);
    cmp(in_sleep, 3'h0);
    irq_enabled_pending <= 1'h0;
    wait_run;
    go <= 1'h1;
    op_idle <= 1'h1;
    tk(1);
    go <= 1'h0;
    wdt_timeout <= 1'h1;
    tk(1);
    wdt_timeout <= 1'h0;
    tk(1);
    cmp(in_idle, 3'h0);
    cmp(cpu_run, 3'h1);
    tk(30);
    osc_clk_ok <= 1'h0;
    tk(2);
    cmp(clock_fail_trap, 3'h1);
    cmp(cur_osc_sel, 3'h0);
    osc_clk_ok <= 1'h1;
    tk(5);
    cmp(clock_fail_trap, 3'h1);
    end_sim;
  end
endmodule // csps_ctrl_test

bind csps_ctrl csps_chk csps_chk_i (.*);
